//--- bench/sscs_ctrl_model.sv
`timescale 1ns/1ns
// machine controller side: presents input levels and the analog reference
module sscs_ctrl_model (
    // clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_reset,
    // requests from the test sequence
    input  wire logic [8:0]         i_di_cmd,
    input  wire logic signed [31:0] i_analog_cmd,
    // levels toward the drive
    output logic      [8:0]         o_digital_input,
    output logic signed [31:0]      o_analog_speed
);
    logic [8:0]         di_q;
    logic [8:0]         di_d;
    logic signed [31:0] ana_q;
    logic signed [31:0] ana_d;

    // levels only change on a clock edge, as from a real output card
    always_comb begin
        di_d  = i_di_cmd;
        ana_d = i_analog_cmd;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            di_q  <= 9'h000;
            ana_q <= 32'h0000_0000;
        end else begin
            di_q  <= di_d;
            ana_q <= ana_d;
        end
    end

    assign o_digital_input = di_q;
    assign o_analog_speed  = ana_q;
endmodule

//--- bench/tb.sv
`timescale 1ns/1ns
module tb;
    import sscs_pkg::*;
    logic               i_clock = 1'b0;
    logic               i_reset = 1'b1;
    logic [7:0]         i_addr  = 8'h00;
    logic [31:0]        i_wdata = 32'h0000_0000;
    logic               i_write = 1'b0;
    logic               i_read  = 1'b0;
    logic [31:0]        o_rdata;
    logic [8:0]         di_cmd  = 9'h000;
    logic signed [31:0] ana_cmd = 32'h0000_0000;
    logic [8:0]         di_w;
    logic signed [31:0] ana_w;
    logic               up = 1'b0, down = 1'b0, kset = 1'b0, kmode = 1'b0;
    logic signed [31:0] o_speed_cmd;
    logic               o_motor_enable, o_torque_limit_enable, o_speed_mode;
    logic [7:0]         o_alarm_code;
    int                 err_count = 0;
    int                 samples_checked = 0;
    logic [31:0]        exp_spd [4];
    logic [7:0]         fn_def [9];

    initial begin
        forever #10 i_clock = ~i_clock;
    end

    sscs_ctrl_model i_ctrl (.i_clock(i_clock), .i_reset(i_reset), .i_di_cmd(di_cmd), .i_analog_cmd(ana_cmd),
                            .o_digital_input(di_w), .o_analog_speed(ana_w));

    sscs_top #(.NUM_DI(9)) i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_digital_input(di_w), .i_analog_speed(ana_w),
        .i_key_up(up), .i_key_down(down), .i_key_set(kset), .i_key_mode(kmode), .o_speed_cmd(o_speed_cmd),
        .o_motor_enable(o_motor_enable), .o_torque_limit_enable(o_torque_limit_enable),
        .o_alarm_code(o_alarm_code), .o_speed_mode(o_speed_mode));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // input path plus partner register: a few edges cover the whole latency
    task automatic settle();
        repeat (5) @(posedge i_clock);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask

    task automatic setdi(input logic [8:0] v);
        @(posedge i_clock);
        di_cmd <= v;
        settle();
    endtask

    task automatic tap(input logic s, input logic m);
        @(posedge i_clock);
        kset  <= s;
        kmode <= m;
        @(posedge i_clock);
        kset  <= 1'b0;
        kmode <= 1'b0;
        settle();
    endtask

    task automatic restart();
        @(posedge i_clock);
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        settle();
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge i_clock);
        err_count++;
        conclude();
    end

    initial begin
        fn_def = '{FN_SON, FN_TORQUE_LIMIT_ENABLE_IN, FN_SPEED_SELECT_BIT0, FN_SPEED_SELECT_BIT1, FN_ALARM_RESET_IN, FN_REV_LIM, FN_FWD_LIM, FN_ESTOP, FN_NONE};
        exp_spd = '{32'h0000_04D2, 32'h0000_7530, 32'h0000_03E8, 32'hFFFF_8AD0};
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        settle();
        chk({31'h0, o_motor_enable}, 32'h0000_0000);
        rd(ADDR_INERTIA, 32'h0000_0032);
        rd(ADDR_JOG_SPEED, 32'h0000_0014);
        for (int k = 0; k < 9; k++) rd(ADDR_FUNC_BASE + 8'(4 * k), {24'h0, fn_def[k]});
        rd(8'h3C, 32'h0000_0000);
        // default estop and limit inputs raise latched alarms
        setdi(9'h080);
        chk({24'h0, o_alarm_code}, {24'h0, ALARM_ESTOP});
        setdi(9'h000);
        chk({24'h0, o_alarm_code}, {24'h0, ALARM_ESTOP});
        setdi(9'h010);
        chk({24'h0, o_alarm_code}, 32'h0000_0000);
        setdi(9'h060);
        chk({24'h0, o_alarm_code}, {24'h0, ALARM_REV_LIM});
        setdi(9'h000);
        setdi(9'h010);
        wr(ADDR_FUNC_BASE + 8'h1C, 32'h0000_0000);
        setdi(9'h080);
        chk({24'h0, o_alarm_code}, 32'h0000_0000);
        // mode only takes hold after a restart
        wr(ADDR_CTRL_MODE, 32'h0000_0002);
        settle();
        chk({31'h0, o_speed_mode}, 32'h0000_0000);
        rd(ADDR_ACT_MODE, 32'h0000_0000);
        @(posedge i_clock);
        di_cmd <= 9'h000;
        restart();
        chk({31'h0, o_speed_mode}, 32'h0000_0001);
        rd(ADDR_ACT_MODE, 32'h0000_0002);
        wr(ADDR_SPD_FIRST, exp_spd[1]);
        wr(ADDR_SPD_SECOND, exp_spd[2]);
        wr(ADDR_SPD_THIRD, exp_spd[3]);
        ana_cmd <= exp_spd[0];
        for (int s = 0; s < 4; s++) begin
            setdi({5'h00, 2'(s), 2'b01});
            chk(o_speed_cmd, exp_spd[s]);
            chk({31'h0, o_motor_enable}, 32'h0000_0001);
        end
        setdi(9'h002);
        chk({31'h0, o_motor_enable}, 32'h0000_0000);
        chk({31'h0, o_torque_limit_enable}, 32'h0000_0001);
        wr(ADDR_SPD_FIRST, 32'h0000_EA60);
        rd(ADDR_SPD_FIRST, 32'h0000_C350);
        wr(ADDR_SPD_FIRST, 32'hFFFE_EE90);
        rd(ADDR_SPD_FIRST, 32'hFFFF_3CB0);
        setdi(9'h005);
        chk(o_speed_cmd, 32'hFFFF_3CB0);
        // move servo enable from the first input to the ninth
        wr(ADDR_FUNC_BASE, 32'h0000_0000);
        wr(ADDR_FUNC_BASE + 8'h20, {24'h0, FN_SON});
        setdi(9'h001);
        chk({31'h0, o_motor_enable}, 32'h0000_0000);
        setdi(9'h100);
        chk({31'h0, o_motor_enable}, 32'h0000_0001);
        setdi(9'h000);
        chk({31'h0, o_motor_enable}, 32'h0000_0000);
        wr(ADDR_SW_SON, 32'h0000_0001);
        settle();
        chk({31'h0, o_motor_enable}, 32'h0000_0001);
        // jog: edit speed 20 -> 22, then run both ways
        tap(1'b1, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0100);
        @(posedge i_clock);
        up <= 1'b1;
        repeat (3) @(posedge i_clock);
        up   <= 1'b0;
        down <= 1'b1;
        @(posedge i_clock);
        down <= 1'b0;
        settle();
        rd(ADDR_JOG_SPEED, 32'h0000_0016);
        tap(1'b1, 1'b0);
        rd(ADDR_STATUS, 32'h0000_0200);
        @(posedge i_clock);
        up <= 1'b1;
        settle();
        chk(o_speed_cmd, 32'h0000_00DC);
        @(posedge i_clock);
        up <= 1'b0;
        settle();
        chk(o_speed_cmd, 32'h0000_0000);
        @(posedge i_clock);
        down <= 1'b1;
        settle();
        chk(o_speed_cmd, 32'hFFFF_FF24);
        @(posedge i_clock);
        down <= 1'b0;
        tap(1'b0, 1'b1);
        rd(ADDR_STATUS, 32'h0000_0000);
        conclude();
    end
endmodule

//--- rtl/sscs_pkg.sv
package sscs_pkg;
    // ------------------------------------------------------------
    // register map (word index = byte address / 4)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_MODE  = 8'h00;
    localparam logic [7:0] ADDR_SPD_FIRST  = 8'h04;
    localparam logic [7:0] ADDR_SPD_SECOND = 8'h08;
    localparam logic [7:0] ADDR_SPD_THIRD  = 8'h0C;
    localparam logic [7:0] ADDR_SW_SON     = 8'h10;
    localparam logic [7:0] ADDR_JOG_SPEED  = 8'h14;
    localparam logic [7:0] ADDR_INERTIA    = 8'h18;
    localparam logic [7:0] ADDR_STATUS     = 8'h1C;
    localparam logic [7:0] ADDR_ACT_MODE   = 8'h20;
    localparam logic [7:0] ADDR_FUNC_BASE  = 8'h40;
    localparam int         NUM_INPUTS      = 9;
    // ------------------------------------------------------------
    // function codes
    // ------------------------------------------------------------
    localparam logic [7:0] FN_NONE     = 8'd0;
    localparam logic [7:0] FN_SON      = 8'd101;
    localparam logic [7:0] FN_ALARM_RESET_IN     = 8'd102;
    localparam logic [7:0] FN_TORQUE_LIMIT_ENABLE_IN    = 8'd109;
    localparam logic [7:0] FN_SPEED_SELECT_BIT0     = 8'd114;
    localparam logic [7:0] FN_SPEED_SELECT_BIT1     = 8'd115;
    localparam logic [7:0] FN_ESTOP    = 8'd21;
    localparam logic [7:0] FN_REV_LIM  = 8'd22;
    localparam logic [7:0] FN_FWD_LIM  = 8'd23;
    // ------------------------------------------------------------
    // values and defaults
    // ------------------------------------------------------------
    localparam logic [7:0]  MODE_SPEED      = 8'd2;
    localparam logic [7:0]  MODE_RESET      = 8'd0;
    localparam logic [31:0] SPD_MAX         = 32'sd50000;
    localparam logic [31:0] SPD_MIN         = -32'sd50000;
    localparam logic [15:0] JOG_DEFAULT     = 16'd20;
    localparam logic [15:0] INERTIA_DEFAULT = 16'd50;
    localparam logic [7:0]  ALARM_NONE      = 8'd0;
    localparam logic [7:0]  ALARM_ESTOP     = 8'd13;
    localparam logic [7:0]  ALARM_REV_LIM   = 8'd14;
    localparam logic [7:0]  ALARM_FWD_LIM   = 8'd15;
    localparam logic [1:0]  SRC_ANALOG      = 2'd0;
    localparam logic [1:0]  SRC_FIRST       = 2'd1;
    localparam logic [1:0]  SRC_SECOND      = 2'd2;
    localparam logic [1:0]  SRC_THIRD       = 2'd3;

    typedef enum logic [1:0] {
        SSCS_JOG_IDLE = 2'b00,
        SSCS_JOG_EDIT = 2'b01,
        SSCS_JOG_RUN  = 2'b10
    } sscs_jog_type;
endpackage

//--- rtl/sscs_top.sv
// Decided for this implementation: the address-and-strobe port and the address map.
`timescale 1ns/1ns
module sscs_top
    import sscs_pkg::*;
#(
    parameter int NUM_DI = 9
) (
    // clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_reset,
    // register port
    input  wire logic [7:0]         i_addr,
    input  wire logic [31:0]        i_wdata,
    input  wire logic               i_write,
    input  wire logic               i_read,
    output logic      [31:0]        o_rdata,
    // drive inputs
    input  wire logic [NUM_DI-1:0]  i_digital_input,
    input  wire logic signed [31:0] i_analog_speed,
    // keypad
    input  wire logic               i_key_up,
    input  wire logic               i_key_down,
    input  wire logic               i_key_set,
    input  wire logic               i_key_mode,
    // outputs
    output logic signed [31:0]      o_speed_cmd,
    output logic                    o_motor_enable,
    output logic                    o_torque_limit_enable,
    output logic [7:0]              o_alarm_code,
    output logic                    o_speed_mode
);
    import sscs_pkg::*;

    if (NUM_DI != NUM_INPUTS) begin : g_bad_num_di
        $error("sscs_top: NUM_DI must equal NUM_INPUTS");
    end

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic signed [31:0] clamp_spd(input logic signed [31:0] v);
        if (v > $signed(SPD_MAX)) return $signed(SPD_MAX);
        else if (v < $signed(SPD_MIN)) return $signed(SPD_MIN);
        else return v;
    endfunction

    function automatic logic fn_active(input logic [NUM_DI-1:0] lvl,
                                       input logic [NUM_DI*8-1:0] fns,
                                       input logic [7:0] code);
        logic r;
        r = 1'b0;
        for (int k = 0; k < NUM_DI; k++) begin
            if (fns[k*8 +: 8] == code && code != FN_NONE && lvl[k]) r = 1'b1;
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    // the configured mode is kept over a restart, like a stored parameter;
    // only the power-up value comes from the initialiser
    logic [7:0]         mode_cfg_q = MODE_RESET;
    logic [7:0]         mode_cfg_d;
    logic               speed_mode_q;
    logic [7:0]         mode_act_q, mode_act_d;
    logic               started_q, started_d;
    logic signed [31:0] speed_select_bit1_q, speed_select_bit1_d, spd2_q, spd2_d, spd3_q, spd3_d;
    logic               sw_son_q, sw_son_d;
    logic [15:0]        jog_q, jog_d;
    logic [15:0]        inertia_q, inertia_d;
    logic [NUM_DI*8-1:0] fn_q, fn_d;
    logic [31:0]        rdata_q, rdata_d;
    logic [7:0]         alarm_q;
    sscs_jog_type       jog_st_q;

    always_comb begin
        mode_cfg_d = mode_cfg_q;
        mode_act_d = mode_act_q;
        started_d  = 1'b1;
        speed_select_bit1_d     = speed_select_bit1_q;
        spd2_d     = spd2_q;
        spd3_d     = spd3_q;
        sw_son_d   = sw_son_q;
        jog_d      = jog_q;
        inertia_d  = inertia_q;
        fn_d       = fn_q;
        rdata_d    = 32'h0000_0000;
        if (!started_q) mode_act_d = mode_cfg_q;
        if (jog_st_q == SSCS_JOG_EDIT) begin
            if (i_key_up) jog_d = jog_q + 16'h0001;
            else if (i_key_down && jog_q != 16'h0000) jog_d = jog_q - 16'h0001;
        end
        if (i_write) begin
            unique case (i_addr)
                ADDR_CTRL_MODE:  mode_cfg_d = i_wdata[7:0];
                ADDR_SPD_FIRST:  speed_select_bit1_d = clamp_spd(i_wdata);
                ADDR_SPD_SECOND: spd2_d = clamp_spd(i_wdata);
                ADDR_SPD_THIRD:  spd3_d = clamp_spd(i_wdata);
                ADDR_SW_SON:     sw_son_d = i_wdata[0];
                ADDR_JOG_SPEED:  jog_d = i_wdata[15:0];
                ADDR_INERTIA:    inertia_d = i_wdata[15:0];
                default: begin
                    for (int k = 0; k < NUM_DI; k++) begin
                        if (i_addr == ADDR_FUNC_BASE + 8'(k*4)) fn_d[k*8 +: 8] = i_wdata[7:0];
                    end
                end
            endcase
        end
        if (i_read) begin
            unique case (i_addr)
                ADDR_CTRL_MODE:  rdata_d = {24'h00_0000, mode_cfg_q};
                ADDR_SPD_FIRST:  rdata_d = speed_select_bit1_q;
                ADDR_SPD_SECOND: rdata_d = spd2_q;
                ADDR_SPD_THIRD:  rdata_d = spd3_q;
                ADDR_SW_SON:     rdata_d = {31'h0000_0000, sw_son_q};
                ADDR_JOG_SPEED:  rdata_d = {16'h0000, jog_q};
                ADDR_INERTIA:    rdata_d = {16'h0000, inertia_q};
                ADDR_STATUS:     rdata_d = {22'h00_0000, jog_st_q, alarm_q};
                ADDR_ACT_MODE:   rdata_d = {24'h00_0000, mode_act_q};
                default: begin
                    for (int k = 0; k < NUM_DI; k++) begin
                        if (i_addr == ADDR_FUNC_BASE + 8'(k*4)) rdata_d = {24'h00_0000, fn_q[k*8 +: 8]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            mode_act_q <= MODE_RESET;
            speed_mode_q <= 1'b0;
            started_q  <= 1'b0;
            speed_select_bit1_q     <= 32'h0000_0000;
            spd2_q     <= 32'h0000_0000;
            spd3_q     <= 32'h0000_0000;
            sw_son_q   <= 1'b0;
            jog_q      <= JOG_DEFAULT;
            inertia_q  <= INERTIA_DEFAULT;
            fn_q       <= {8'd0, FN_ESTOP, FN_FWD_LIM, FN_REV_LIM,
                           FN_ALARM_RESET_IN, FN_SPEED_SELECT_BIT1, FN_SPEED_SELECT_BIT0, FN_TORQUE_LIMIT_ENABLE_IN, FN_SON};
            rdata_q    <= 32'h0000_0000;
        end else begin
            mode_cfg_q <= mode_cfg_d;
            mode_act_q <= mode_act_d;
            speed_mode_q <= (mode_act_d == MODE_SPEED);
            started_q  <= started_d;
            speed_select_bit1_q     <= speed_select_bit1_d;
            spd2_q     <= spd2_d;
            spd3_q     <= spd3_d;
            sw_son_q   <= sw_son_d;
            jog_q      <= jog_d;
            inertia_q  <= inertia_d;
            fn_q       <= fn_d;
            rdata_q    <= rdata_d;
        end
    end
    assign o_rdata = rdata_q;

    // ------------------------------------------------------------
    // input functions and alarms
    // ------------------------------------------------------------
    logic [NUM_DI-1:0] di_q;
    logic [7:0]        alarm_d;
    logic              son_q, son_d, trq_q, trq_d;
    logic [1:0]        sel;

    assign sel = {fn_active(di_q, fn_q, FN_SPEED_SELECT_BIT1), fn_active(di_q, fn_q, FN_SPEED_SELECT_BIT0)};

    always_comb begin
        alarm_d = alarm_q;
        if (fn_active(di_q, fn_q, FN_ALARM_RESET_IN)) alarm_d = ALARM_NONE;
        // a new alarm wins over a simultaneous reset so no event is lost
        if (fn_active(di_q, fn_q, FN_ESTOP)) alarm_d = ALARM_ESTOP;
        else if (fn_active(di_q, fn_q, FN_REV_LIM)) alarm_d = ALARM_REV_LIM;
        else if (fn_active(di_q, fn_q, FN_FWD_LIM)) alarm_d = ALARM_FWD_LIM;
        son_d = (fn_active(di_q, fn_q, FN_SON) || sw_son_q) && (alarm_d == ALARM_NONE);
        trq_d = fn_active(di_q, fn_q, FN_TORQUE_LIMIT_ENABLE_IN);
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            di_q    <= '0;
            alarm_q <= ALARM_NONE;
            son_q   <= 1'b0;
            trq_q   <= 1'b0;
        end else begin
            di_q    <= i_digital_input;
            alarm_q <= alarm_d;
            son_q   <= son_d;
            trq_q   <= trq_d;
        end
    end

    // ------------------------------------------------------------
    // keypad jog
    // ------------------------------------------------------------
    sscs_jog_type jog_st_d;

    always_comb begin
        jog_st_d = jog_st_q;
        unique case (jog_st_q)
            SSCS_JOG_IDLE: if (i_key_set && sw_son_q) jog_st_d = SSCS_JOG_EDIT;
            SSCS_JOG_EDIT: if (i_key_set) jog_st_d = SSCS_JOG_RUN;
                           else if (i_key_mode) jog_st_d = SSCS_JOG_IDLE;
            SSCS_JOG_RUN:  if (i_key_mode) jog_st_d = SSCS_JOG_IDLE;
            default:       jog_st_d = SSCS_JOG_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) jog_st_q <= SSCS_JOG_IDLE;
        else jog_st_q <= jog_st_d;
    end

    // ------------------------------------------------------------
    // speed command, units of 0.1 r/min
    // ------------------------------------------------------------
    logic signed [31:0] cmd_q, cmd_d;
    logic               en_q, en_d;
    logic signed [31:0] jog_tenth;

    // jog speed is held in whole r/min; scale it to the command unit
    assign jog_tenth = $signed({16'h0000, jog_q}) * 32'sd10;

    always_comb begin
        en_d = son_d;
        unique case (sel)
            SRC_ANALOG: cmd_d = i_analog_speed;
            SRC_FIRST:  cmd_d = speed_select_bit1_q;
            SRC_SECOND: cmd_d = spd2_q;
            SRC_THIRD:  cmd_d = spd3_q;
        endcase
        if (jog_st_q == SSCS_JOG_RUN) begin
            if (i_key_up) cmd_d = jog_tenth;
            else if (i_key_down) cmd_d = -jog_tenth;
            else cmd_d = 32'h0000_0000;
            en_d = sw_son_q && (alarm_d == ALARM_NONE) && (i_key_up || i_key_down);
        end
        if (!en_d) cmd_d = 32'h0000_0000;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            cmd_q <= 32'h0000_0000;
            en_q  <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            en_q  <= en_d;
        end
    end

    assign o_speed_cmd           = cmd_q;
    assign o_motor_enable        = en_q;
    assign o_torque_limit_enable = trq_q;
    assign o_alarm_code          = alarm_q;
    assign o_speed_mode          = speed_mode_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_spd_clamp: assert property (@(posedge i_clock) disable iff (i_reset)
        $signed(speed_select_bit1_q) <= $signed(SPD_MAX) && $signed(speed_select_bit1_q) >= $signed(SPD_MIN))
        else $error("first speed out of range");
    a_mode_hold: assert property (@(posedge i_clock) disable iff (i_reset)
        started_q && $past(started_q) |-> $stable(mode_act_q))
        else $error("mode changed without restart");
    a_sel_first: assert property (@(posedge i_clock) disable iff (i_reset)
        sel == SRC_FIRST && son_d && jog_st_q != SSCS_JOG_RUN |=> cmd_q == $past(speed_select_bit1_q))
        else $error("first speed not selected");
    a_sel_third: assert property (@(posedge i_clock) disable iff (i_reset)
        sel == SRC_THIRD && son_d && jog_st_q != SSCS_JOG_RUN |=> cmd_q == $past(spd3_q))
        else $error("third speed not selected");
    a_sel_analog: assert property (@(posedge i_clock) disable iff (i_reset)
        sel == SRC_ANALOG && son_d && jog_st_q != SSCS_JOG_RUN |=> cmd_q == $past(i_analog_speed))
        else $error("analog not selected");
    a_off_zero: assert property (@(posedge i_clock) disable iff (i_reset)
        !o_motor_enable |-> o_speed_cmd == 32'h0000_0000)
        else $error("command while disabled");
    a_alarm_off: assert property (@(posedge i_clock) disable iff (i_reset)
        alarm_q != ALARM_NONE |-> !o_motor_enable)
        else $error("enabled during alarm");
    a_jog_stop: assert property (@(posedge i_clock) disable iff (i_reset)
        jog_st_q == SSCS_JOG_RUN && !i_key_up && !i_key_down |=> o_speed_cmd == 32'h0000_0000)
        else $error("jog did not stop");
    c_jog_run: cover property (@(posedge i_clock) jog_st_q == SSCS_JOG_RUN && i_key_up);
    c_estop:   cover property (@(posedge i_clock) alarm_q == ALARM_ESTOP);
    c_third:   cover property (@(posedge i_clock) sel == SRC_THIRD && o_motor_enable);
endmodule
